// File: include/snp_map.svh
// register offsets, field positions, reset values and timing counts for the packetizer
// Function
// - two 8-bit end markers, 00..FF, zero means unused, both reset unused
// - no marker set: every received byte is sent at once as its own frame
// - marker set: bytes are held until the marker, then sent as one frame
// - second marker zero ends on first; else first then second back to back
// - both markers zero disables marker framing
// - a full 1K buffer is sent as a frame and emptied
// - idle flush timeout 0..65535 ms, reset 0, zero disables it
// - nonzero timeout flushes buffered bytes after that many quiet milliseconds
// - idle flush also works while waiting for an end marker
// - startup trigger requests the outgoing connection right after reset
// - on-data trigger defers the connection request to the first byte
// - inactivity close timer runs only with the on-data trigger
// - up to four remote targets; the count is only stored and read back
// - datagram listen port 1..65535, reset 4001
// - nonzero inactivity time closes connection after quiet ms both ways
`ifndef SNP_MAP_SVH
`define SNP_MAP_SVH
`define SNP_ADR_MARKER 6'h00
`define SNP_ADR_FLUSH 6'h04
`define SNP_ADR_CTRL 6'h08
`define SNP_ADR_INACT 6'h0C
`define SNP_ADR_PORT 6'h10
`define SNP_ADR_STATUS 6'h14
`define SNP_CTRL_TRIG_BIT 0
`define SNP_CTRL_TGT_LSB 1
`define SNP_CTRL_TGT_W 2
`define SNP_PORT_RST 16'h0FA1
`define SNP_BUF_DEPTH 1024
`define SNP_MS_NS 1000000
`define SNP_CLK_NS 10
`define SNP_MS_CYCLES (`SNP_MS_NS / `SNP_CLK_NS)
`define SNP_TGT_MAX 4
`endif

// File: include/snp_pkg.sv
// types shared by the packetizer modules
package snp_pkg;
  typedef enum logic [2:0] {
    SNP_IDLE = 3'b001,
    SNP_FILL = 3'b010,
    SNP_SEND = 3'b100
  } snp_state_e;
  typedef logic [9:0] snp_ptr_t;
endpackage

// File: include/snp_mem_if.sv
// port bundle between packetizer and its holding buffer
`timescale 1ns/10ps
interface snp_mem_if #(parameter int AW = 10);
  logic we;
  logic [AW-1:0] waddr;
  logic [7:0] wdata;
  logic [AW-1:0] raddr;
  logic [7:0] rdata;
  modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// File: rtl/snp_buf_mem.sv
// holding buffer memory with registered read data
`timescale 1ns/10ps
module snp_buf_mem #(
  parameter int AW = 10
) (
  input wire logic clk_i,
  snp_mem_if.mem m
);
  logic [7:0] mem_q [0:(1<<AW)-1];
  logic [7:0] rd_q;
  always_ff @(posedge clk_i) begin
    if (m.we) begin
      mem_q[m.waddr] <= m.wdata;
    end
    rd_q <= mem_q[m.raddr];
  end
  assign m.rdata = rd_q;
endmodule

// File: rtl/snp_packetizer.sv
// serial-to-network packetizer with wishbone configuration slave
//
// Added by the designer: the address map and the Wishbone slave port.
`timescale 1ns/10ps
`include "snp_map.svh"
module snp_packetizer #(
  parameter int DEPTH = `SNP_BUF_DEPTH,
  parameter int MS_CYCLES = `SNP_MS_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // serial byte stream in
  input wire logic ser_valid_i,
  input wire logic [7:0] ser_data_i,
  input wire logic ser_tx_act_i,
  // network byte stream out
  output logic net_valid_o,
  output logic [7:0] net_data_o,
  output logic net_last_o,
  input wire logic net_ready_i,
  // connection control
  output logic conn_open_o,
  output logic conn_close_o
);
  import snp_pkg::*;
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [7:0] mark1;
    logic [7:0] mark2;
    logic [15:0] flush_ms;
    logic [15:0] inact_ms;
    logic [15:0] port;
    logic trig_data;
    logic [1:0] tgt_cnt;
    logic ack;
    logic [31:0] rdat;
    snp_state_e st;
    logic m1_seen;
    logic [AW:0] cnt;
    logic [AW:0] rd;
    logic [31:0] tick;
    logic [15:0] idle_ms;
    logic [15:0] inact_cnt;
    logic nv;
    logic [7:0] nd;
    logic nl;
    logic pend;
    logic opened;
    logic close;
    logic [AW:0] send_len;
  } snp_state_s;

  snp_state_s q, d;
  snp_mem_if #(.AW(AW)) mif ();

  snp_buf_mem #(.AW(AW)) u_mem (
    .clk_i(clk_i),
    .m(mif.mem)
  );

  function automatic logic [31:0] rd_mux(input snp_state_s s, input logic [5:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      `SNP_ADR_MARKER: r = {16'h0000, s.mark2, s.mark1};
      `SNP_ADR_FLUSH: r = {16'h0000, s.flush_ms};
      `SNP_ADR_CTRL: r = {29'h0000_0000, s.tgt_cnt, s.trig_data};
      `SNP_ADR_INACT: r = {16'h0000, s.inact_ms};
      `SNP_ADR_PORT: r = {16'h0000, s.port};
      `SNP_ADR_STATUS: r = {s.opened, 7'h00, 3'h0, s.st, 7'h00, 11'(s.cnt)};
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  logic wb_req;
  logic ms_tick;
  logic mark_en;
  logic hit;
  logic full;
  logic flush;
  assign wb_req = wb_cyc_i && wb_stb_i && !q.ack;
  assign ms_tick = (q.tick == 32'(MS_CYCLES - 1));
  assign mark_en = (q.mark1 != 8'h00) || (q.mark2 != 8'h00);

  always_comb begin
    d = q;
    hit = 1'b0;
    full = 1'b0;
    flush = 1'b0;
    mif.we = 1'b0;
    mif.waddr = q.cnt[AW-1:0];
    mif.wdata = ser_data_i;
    mif.raddr = q.rd[AW-1:0];
    // bus slave: single-cycle ack, ack drops the cycle after
    d.ack = wb_req;
    if (wb_req) begin
      d.rdat = rd_mux(q, wb_adr_i);
    end
    if (wb_req && wb_we_i) begin
      case (wb_adr_i)
        `SNP_ADR_MARKER: begin
          if (wb_sel_i[0]) d.mark1 = wb_dat_i[7:0];
          if (wb_sel_i[1]) d.mark2 = wb_dat_i[15:8];
        end
        `SNP_ADR_FLUSH: begin
          if (wb_sel_i[0]) d.flush_ms[7:0] = wb_dat_i[7:0];
          if (wb_sel_i[1]) d.flush_ms[15:8] = wb_dat_i[15:8];
        end
        `SNP_ADR_CTRL: begin
          if (wb_sel_i[0]) begin
            d.trig_data = wb_dat_i[`SNP_CTRL_TRIG_BIT];
            d.tgt_cnt = wb_dat_i[`SNP_CTRL_TGT_LSB +: `SNP_CTRL_TGT_W];
          end
        end
        `SNP_ADR_INACT: begin
          if (wb_sel_i[0]) d.inact_ms[7:0] = wb_dat_i[7:0];
          if (wb_sel_i[1]) d.inact_ms[15:8] = wb_dat_i[15:8];
        end
        `SNP_ADR_PORT: begin
          // zero is not a legal port and is ignored
          if (wb_sel_i[1:0] == 2'b11 && wb_dat_i[15:0] != 16'h0000) begin
            d.port = wb_dat_i[15:0];
          end
        end
        default: ;
      endcase
    end

    d.tick = ms_tick ? 32'h0000_0000 : q.tick + 32'h0000_0001;
    d.close = 1'b0;
    d.nv = q.nv && !net_ready_i;

    // connection trigger
    if (!q.trig_data && !q.opened) begin
      d.opened = 1'b1;
    end
    if (q.trig_data && !q.opened && ser_valid_i) begin
      d.opened = 1'b1;
    end
    // inactivity close, only with on-data trigger
    if (q.trig_data && q.opened && q.inact_ms != 16'h0000) begin
      if (ser_valid_i || ser_tx_act_i) begin
        d.inact_cnt = 16'h0000;
      end else if (ms_tick) begin
        if (q.inact_cnt + 16'h0001 >= q.inact_ms) begin
          d.opened = 1'b0;
          d.close = 1'b1;
          d.inact_cnt = 16'h0000;
        end else begin
          d.inact_cnt = q.inact_cnt + 16'h0001;
        end
      end
    end else begin
      d.inact_cnt = 16'h0000;
    end

    case (q.st)
      SNP_IDLE, SNP_FILL: begin
        // serial bytes are dropped only while a frame drains (SEND)
        if (ser_valid_i) begin
          mif.we = 1'b1;
          d.cnt = q.cnt + 1'b1;
          d.idle_ms = 16'h0000;
          d.st = SNP_FILL;
          if (!mark_en) begin
            hit = 1'b1;
          end else if (q.mark2 == 8'h00) begin
            hit = (ser_data_i == q.mark1);
          end else begin
            hit = q.m1_seen && (ser_data_i == q.mark2);
          end
          d.m1_seen = (ser_data_i == q.mark1) && (q.mark1 != 8'h00);
          full = (q.cnt == (AW+1)'(DEPTH - 1));
          if (hit || full) begin
            flush = 1'b1;
          end
        end else if (q.st == SNP_FILL && q.flush_ms != 16'h0000 && ms_tick) begin
          if (q.idle_ms + 16'h0001 >= q.flush_ms) begin
            flush = 1'b1;
          end else begin
            d.idle_ms = q.idle_ms + 16'h0001;
          end
        end
        if (flush) begin
          d.send_len = ser_valid_i ? q.cnt + 1'b1 : q.cnt;
          d.rd = '0;
          d.pend = 1'b0;
          d.st = SNP_SEND;
          d.idle_ms = 16'h0000;
          d.m1_seen = 1'b0;
        end
      end
      SNP_SEND: begin
        // read data lands one cycle after raddr; pend marks it valid
        if (!q.nv || net_ready_i) begin
          if (q.pend) begin
            d.nv = 1'b1;
            d.nd = mif.rdata;
            d.nl = (q.rd == q.send_len);
            d.pend = 1'b0;
            if (q.rd == q.send_len) begin
              d.st = SNP_IDLE;
              d.cnt = '0;
            end
          end else if (q.rd < q.send_len) begin
            d.rd = q.rd + 1'b1;
            d.pend = 1'b1;
          end
        end
      end
      default: d.st = SNP_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.st <= SNP_IDLE;
      q.port <= `SNP_PORT_RST;
    end else begin
      q <= d;
    end
  end

  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.rdat;
  assign net_valid_o = q.nv;
  assign net_data_o = q.nd;
  assign net_last_o = q.nl;
  assign conn_open_o = q.opened;
  assign conn_close_o = q.close;
endmodule

// File: bench/snp_monitor.sv
// port assertions for the packetizer
`timescale 1ns/10ps
module snp_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic net_valid_o,
  input wire logic [7:0] net_data_o,
  input wire logic net_last_o,
  input wire logic net_ready_i,
  input wire logic conn_open_o,
  input wire logic conn_close_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack long");
  chk_unmapped_zero: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o
    && wb_adr_i >= 6'h18 |=> wb_dat_o == 32'h0000_0000) else $error("unmapped");
  chk_net_hold: assert property (net_valid_o && !net_ready_i |=> net_valid_o
    && $stable(net_data_o) && $stable(net_last_o)) else $error("net dropped");
  chk_frame_end: assert property (net_valid_o && net_ready_i && net_last_o |=> !net_valid_o)
    else $error("frame end");
  chk_open_boot: assert property ($fell(rst_i) |=> conn_open_o)
    else $error("no open");
  chk_close_pulse: assert property (conn_close_o |=> !conn_close_o)
    else $error("close long");
  chk_close_drop: assert property (conn_close_o |-> ##[0:1] !conn_open_o)
    else $error("open kept");
endmodule

// File: bench/snp_net_sink.sv
// network side sink: stalls every other cycle and records bytes
`timescale 1ns/10ps
module snp_net_sink (
  input wire logic clk_i,
  input wire logic valid_i,
  input wire logic [7:0] data_i,
  input wire logic last_i,
  output logic ready_o
);
  logic [8:0] got[$];
  initial ready_o = 1'b0;
  // alternating ready keeps the source holding its byte
  always @(posedge clk_i) begin
    ready_o <= !ready_o;
    if (valid_i && ready_o) got.push_back({last_i, data_i});
  end
endmodule

// File: bench/snp_packetizer_tb.sv
// packetizer testbench
`timescale 1ns/10ps
`include "snp_map.svh"
module snp_packetizer_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [5:0] adr = 6'h00;
  logic [31:0] dat = 32'h0000_0000;
  logic sv = 1'b0;
  logic [7:0] sd = 8'h00;
  logic [3:0] sel = 4'hF;
  logic ta = 1'b0;
  logic [31:0] rdat, wbd;
  logic ack, nv, nl, rdy, op, cl;
  logic [7:0] nd;
  logic [7:0] q[$];
  int num_errors = 0;
  int n_checks = 0;
  int closes = 0;
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) if (cl === 1'b1) closes <= closes + 1;
  snp_packetizer #(.DEPTH(16), .MS_CYCLES(10)) snp_packetizer_i (.clk_i(clk_i),
    .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wbd), .wb_ack_o(ack), .ser_valid_i(sv),
    .ser_data_i(sd), .ser_tx_act_i(ta), .net_valid_o(nv), .net_data_o(nd),
    .net_last_o(nl), .net_ready_i(rdy), .conn_open_o(op), .conn_close_o(cl));
  snp_net_sink snp_net_sink_i (.clk_i(clk_i), .valid_i(nv), .data_i(nd), .last_i(nl),
    .ready_o(rdy));
  task automatic report_and_stop();
    if (num_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // no local limit: a slave that never answers is caught by the watchdog
  task automatic bus(input logic w, input logic [5:0] a, input logic [15:0] d);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, 16'h0000, d};
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rdat = wbd;
    {cyc, stb, we} <= 3'b000;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [5:0] a, input logic [15:0] e);
    bus(1'b0, a, 16'h0000);
    chk(rdat, {16'h0000, e});
  endtask
  task automatic put(input logic [7:0] b);
    {sv, sd} <= {1'b1, b};
    @(posedge clk_i);
    sv <= 1'b0;
    @(posedge clk_i);
  endtask
  // waits for the frame, then a little longer so stray extra bytes show
  task automatic frame(input logic [7:0] b[$]);
    int n;
    for (n = 0; n < 400 && snp_net_sink_i.got.size() < b.size(); n++) @(posedge clk_i);
    repeat (8) @(posedge clk_i);
    chk(snp_net_sink_i.got.size(), b.size());
    foreach (b[i]) chk(32'(snp_net_sink_i.got[i]), 32'({i == b.size() - 1, b[i]}));
    snp_net_sink_i.got.delete();
  endtask
  initial begin
    #200000;
    num_errors++;
    report_and_stop();
  end
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`SNP_ADR_MARKER, 16'h0000);
    rd(`SNP_ADR_FLUSH, 16'h0000);
    rd(`SNP_ADR_CTRL, 16'h0000);
    rd(6'h18, 16'h0000);
    bus(1'b1, `SNP_ADR_PORT, 16'h0000);
    rd(`SNP_ADR_PORT, 16'h0FA1);
    bus(1'b1, `SNP_ADR_PORT, 16'h1234);
    rd(`SNP_ADR_PORT, 16'h1234);
    // a half-width port write must be ignored
    sel <= 4'h1;
    bus(1'b1, `SNP_ADR_PORT, 16'h5678);
    sel <= 4'hF;
    rd(`SNP_ADR_PORT, 16'h1234);
    chk(32'(op), 32'h0000_0001);
    bus(1'b0, `SNP_ADR_STATUS, 16'h0000);
    chk(rdat, 32'h8004_0000);
    put(8'h11);
    frame('{8'h11});
    bus(1'b1, `SNP_ADR_MARKER, 16'h000D);
    q = '{8'h41, 8'h42, 8'h0D};
    foreach (q[i]) put(q[i]);
    frame(q);
    bus(1'b1, `SNP_ADR_MARKER, 16'h0A0D);
    q = '{8'h0D, 8'h43, 8'h0D, 8'h0A};
    foreach (q[i]) put(q[i]);
    frame(q);
    bus(1'b1, `SNP_ADR_FLUSH, 16'h0002);
    q = '{8'h55, 8'h66};
    foreach (q[i]) put(q[i]);
    chk(snp_net_sink_i.got.size(), 32'h0000_0000);
    frame(q);
    bus(1'b1, `SNP_ADR_FLUSH, 16'h0000);
    q.delete();
    for (int i = 0; i < 16; i++) q.push_back(8'h20 + 8'(i));
    foreach (q[i]) put(q[i]);
    frame(q);
    bus(1'b1, `SNP_ADR_MARKER, 16'h0000);
    put(8'h77);
    frame('{8'h77});
    bus(1'b1, `SNP_ADR_INACT, 16'h0002);
    rd(`SNP_ADR_INACT, 16'h0002);
    repeat (60) @(posedge clk_i);
    chk(closes, 32'h0000_0000);
    // transmit activity alone must keep the connection alive
    ta <= 1'b1;
    bus(1'b1, `SNP_ADR_CTRL, 16'h0007);
    rd(`SNP_ADR_CTRL, 16'h0007);
    repeat (40) @(posedge clk_i);
    chk(closes, 32'h0000_0000);
    ta <= 1'b0;
    for (int n = 0; n < 100 && closes == 0; n++) @(posedge clk_i);
    @(posedge clk_i);
    chk(closes, 32'h0000_0001);
    chk(32'(op), 32'h0000_0000);
    put(8'h01);
    repeat (3) @(posedge clk_i);
    chk(32'(op), 32'h0000_0001);
    frame('{8'h01});
    // reset in mid-run must bring every setting back to its default
    bus(1'b1, `SNP_ADR_MARKER, 16'h0A0D);
    bus(1'b1, `SNP_ADR_FLUSH, 16'h0100);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`SNP_ADR_MARKER, 16'h0000);
    rd(`SNP_ADR_FLUSH, 16'h0000);
    rd(`SNP_ADR_INACT, 16'h0000);
    rd(`SNP_ADR_CTRL, 16'h0000);
    rd(`SNP_ADR_PORT, 16'h0FA1);
    chk(32'(op), 32'h0000_0001);
    report_and_stop();
  end
endmodule
bind snp_packetizer snp_monitor snp_monitor_i (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .net_valid_o(net_valid_o),
  .net_data_o(net_data_o), .net_last_o(net_last_o), .net_ready_i(net_ready_i),
  .conn_open_o(conn_open_o), .conn_close_o(conn_close_o));
